// >>> verilog/fogp_fail_logic.sv
/*
  fogp_fail_logic: fault collection, failure flag and fail output drive,
  plus the alternate pin functions of the two pulsed fail pins.
  Assumes single 40 MHz clock, synchronous active-high reset, fault and
  control inputs synchronous to clk; pin levels arrive asynchronously.
*/
`timescale 1ns/100ps
`default_nettype none
module fogp_fail_logic (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire fogp_pkg::fogp_faults_s faults,
  input  wire logic                  faults_present,
  input  wire logic                  overvoltage_reset_enable,
  input  wire logic [1:0]            device_config,
  input  wire logic [2:0]            sbc_mode,
  input  wire logic                  wd_trigger_ok,
  input  wire logic                  sleep_entry,
  input  wire logic                  stop_wd_disable,
  input  wire logic                  uv_recovered,
  input  wire logic                  fail_test_activate,
  input  wire logic                  failure_clear,
  input  wire logic [1:0]            pwm_duty_select,
  input  wire logic                  duty_write,
  input  wire fogp_pkg::fogp_pincfg_s blink_pin_cfg,
  input  wire fogp_pkg::fogp_pincfg_s second_alt_pin_cfg,
  input  wire logic                  cfg_write,
  input  wire logic                  wake_clear,
  input  wire logic                  blink_pin_level,
  input  wire logic                  pwm_pin_level,
  output fogp_pkg::fogp_pin_s        static_fail_out,
  output fogp_pkg::fogp_pin_s        blink_fail_out,
  output fogp_pkg::fogp_pin_s        pwm_fail_out,
  output logic                       device_status_reg,
  output logic                       watchdog_failure_flag,
  output logic                       failsafe_request,
  output logic [1:0]                 wake_status_second,
  output logic [1:0]                 wake_level_status
);
  logic                   failure;
  logic                   next_failure;
  logic                   wd_flag;
  logic                   next_wd_flag;
  logic                   wd_seen;
  logic                   next_wd_seen;
  logic [2:0]             uv_cnt;
  logic [2:0]             next_uv_cnt;
  logic                   fo_active;
  logic                   next_fo_active;
  logic [1:0]             duty;
  logic [1:0]             next_duty;
  fogp_pkg::fogp_pincfg_s cfg2;
  fogp_pkg::fogp_pincfg_s cfg3;
  fogp_pkg::fogp_pincfg_s next_cfg2;
  fogp_pkg::fogp_pincfg_s next_cfg3;
  logic [1:0]             lvl_meta;
  logic [1:0]             lvl_sync;
  logic [1:0]             lvl_prev;
  logic [1:0]             wake_stat;
  logic [1:0]             next_wake_stat;
  logic [1:0]             lvl_out;
  logic [1:0]             next_lvl_out;
  logic                   fs_req;
  logic                   next_fs_req;
  logic                   wd_trip;
  logic                   wd_fs;
  logic                   other_trip;
  logic                   blink_low;
  logic                   pwm_low;
  fogp_pkg::fogp_pin_s    next_fo1;
  fogp_pkg::fogp_pin_s    next_fo2;
  fogp_pkg::fogp_pin_s    next_fo3;
  fogp_pkg::fogp_mode_e   mode;

  assign mode = fogp_pkg::fogp_mode_e'(sbc_mode);

  // pin drive for one pulsed pin from its configuration and the sbc mode
  function automatic fogp_pkg::fogp_pin_s pin_drive(
    input fogp_pkg::fogp_pincfg_s c, input fogp_pkg::fogp_mode_e m,
    input logic act, input logic wave_low);
    fogp_pkg::fogp_pin_s p;
    p = '{o: 1'b0, oe: 1'b0};
    case (c.fn)
      2'h0: begin
        p.oe = act & wave_low;
      end
      2'h3: begin
        // switch off in restart and fail-safe, held elsewhere
        if (c.sw_on && m != fogp_pkg::FOGP_RESTART && m != fogp_pkg::FOGP_FAILSAFE) begin
          p.oe = 1'b1;
          p.o  = c.high_side;
        end
      end
      default: p = '{o: 1'b0, oe: 1'b0}; // off and wake never drive
    endcase
    return p;
  endfunction : pin_drive

  // wake capable except in fail-safe
  function automatic logic wake_on(input fogp_pkg::fogp_pincfg_s c,
                                   input fogp_pkg::fogp_mode_e m);
    return (c.fn == 2'h2) && (m != fogp_pkg::FOGP_FAILSAFE);
  endfunction : wake_on

  // a pin reports its level only when it is not a fail output
  function automatic logic pin_is_gpio(input fogp_pkg::fogp_pincfg_s c);
    return c.fn != 2'h0;
  endfunction : pin_is_gpio

  // configuration and duty accept writes only in normal mode
  function automatic logic cfg_open(input fogp_pkg::fogp_mode_e m);
    return m == fogp_pkg::FOGP_NORMAL;
  endfunction : cfg_open

  fogp_wave u_wave (
    .clk             (clk),
    .reset           (reset),
    .run             (next_fo_active), // next value keeps pulsed pins aligned with static one
    .pwm_duty_select (duty),
    .blink_low       (blink_low),
    .pwm_low         (pwm_low)
  );

  // fault qualification and failure flag
  always_comb begin
    next_uv_cnt = uv_cnt;
    if (uv_recovered)
      next_uv_cnt = '0;
    else if (faults.undervoltage_event && uv_cnt != fogp_pkg::UV_CNT_MAX)
      next_uv_cnt = uv_cnt + 3'h1;
    next_wd_seen = wd_trigger_ok ? 1'b0 : wd_seen; // a new failure still beats a trigger
    wd_trip      = 1'b0;
    wd_fs        = 1'b0;
    if (faults.watchdog_failure_flag_event) begin
      next_wd_seen = 1'b1;
      case (device_config)
        2'h0: begin
          wd_trip = 1'b1;
          wd_fs   = 1'b1;
        end
        2'h1: begin
          wd_trip = wd_seen;
          wd_fs   = wd_seen;
        end
        default: begin
          wd_trip = wd_seen;
          wd_fs   = wd_seen;
        end
      endcase
    end
    other_trip = faults.thermal_shutdown_level2 | faults.primary_regulator_short
               | (faults.overvoltage & overvoltage_reset_enable)
               | (next_uv_cnt == fogp_pkg::UV_CNT_MAX && uv_cnt != fogp_pkg::UV_CNT_MAX);
    next_fs_req = other_trip | wd_fs;
    // the set wins over a clear in the same cycle
    next_failure = failure;
    if (failure_clear && !faults_present && !wd_flag)
      next_failure = 1'b0;
    if (wd_trip || other_trip)
      next_failure = 1'b1;
    next_wd_flag = wd_flag;
    if (wd_trigger_ok || sleep_entry || stop_wd_disable || other_trip)
      next_wd_flag = 1'b0;
    if (faults.watchdog_failure_flag_event && (device_config != 2'h1 || wd_seen))
      next_wd_flag = 1'b1;
    // failure activation persists through restart into normal
    next_fo_active = next_failure | fail_test_activate;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      failure   <= 1'b0;
      wd_flag   <= 1'b0;
      wd_seen   <= 1'b0;
      uv_cnt    <= '0;
      fo_active <= 1'b0;
      fs_req    <= 1'b0;
    end else begin
      failure   <= next_failure;
      wd_flag   <= next_wd_flag;
      wd_seen   <= next_wd_seen;
      uv_cnt    <= next_uv_cnt;
      fo_active <= next_fo_active;
      fs_req    <= next_fs_req;
    end
  end

  // configuration held outside normal mode, never altered by restart
  always_comb begin
    next_duty = duty;
    next_cfg2 = cfg2;
    next_cfg3 = cfg3;
    if (cfg_open(mode) && duty_write)
      next_duty = pwm_duty_select;
    if (cfg_open(mode) && cfg_write) begin
      next_cfg2 = blink_pin_cfg;
      next_cfg3 = second_alt_pin_cfg;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      duty <= fogp_pkg::DUTY_RESET;
      cfg2 <= '0;
      cfg3 <= '0;
    end else begin
      duty <= next_duty;
      cfg2 <= next_cfg2;
      cfg3 <= next_cfg3;
    end
  end

  // pin level synchroniser; resets to the pulled-up idle level, so no false edge
  always_ff @(posedge clk) begin
    if (reset) begin
      lvl_meta <= '1;
      lvl_sync <= '1;
      lvl_prev <= '1;
    end else begin
      lvl_meta <= {pwm_pin_level, blink_pin_level};
      lvl_sync <= lvl_meta;
      lvl_prev <= lvl_sync;
    end
  end

  // wake latching and level report; a new wake beats a clear
  always_comb begin
    next_wake_stat = wake_clear ? 2'h0 : wake_stat;
    if (wake_on(cfg2, mode) && lvl_sync[0] != lvl_prev[0])
      next_wake_stat[0] = 1'b1;
    if (wake_on(cfg3, mode) && lvl_sync[1] != lvl_prev[1])
      next_wake_stat[1] = 1'b1;
    next_lvl_out = lvl_out;
    if (mode == fogp_pkg::FOGP_NORMAL || mode == fogp_pkg::FOGP_STOP) begin
      next_lvl_out[0] = pin_is_gpio(cfg2) ? lvl_sync[0] : 1'b0;
      next_lvl_out[1] = pin_is_gpio(cfg3) ? lvl_sync[1] : 1'b0; // shares test level bit
    end
  end

  // output drive: static pin and any pulsed pin in fail function follow one activation
  always_comb begin
    next_fo1 = '{o: 1'b0, oe: fo_active};
    next_fo2 = pin_drive(cfg2, mode, fo_active, blink_low);
    next_fo3 = pin_drive(cfg3, mode, fo_active, pwm_low);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wake_stat             <= '0;
      lvl_out               <= '0;
      static_fail_out       <= '0;
      blink_fail_out        <= '0;
      pwm_fail_out          <= '0;
      device_status_reg     <= 1'b0;
      watchdog_failure_flag <= 1'b0;
      failsafe_request      <= 1'b0;
      wake_status_second    <= '0;
      wake_level_status     <= '0;
    end else begin
      wake_stat             <= next_wake_stat;
      lvl_out               <= next_lvl_out;
      static_fail_out       <= next_fo1;
      blink_fail_out        <= next_fo2;
      pwm_fail_out          <= next_fo3;
      device_status_reg     <= next_failure;
      watchdog_failure_flag <= next_wd_flag;
      failsafe_request      <= fs_req;
      wake_status_second    <= next_wake_stat;
      wake_level_status     <= next_lvl_out;
    end
  end
endmodule : fogp_fail_logic
`default_nettype wire

// >>> verilog/fogp_pkg.sv
/*
  fogp_pkg: constants and types for the fail output and pin function block.
  Assumes a 40 MHz clock from the internal oscillator.
*/
`default_nettype none
package fogp_pkg;
  localparam int unsigned CLK_HZ        = 40000000;
  localparam int unsigned BLINK_MHZ     = 1250;          // 1.25 Hz in millihertz
  localparam int unsigned PWM_HZ        = 100;
  localparam int unsigned BLINK_PERIOD  = (CLK_HZ / BLINK_MHZ) * 1000;
  localparam int unsigned BLINK_HALF    = BLINK_PERIOD / 2;
  localparam int unsigned PWM_PERIOD    = CLK_HZ / PWM_HZ;
  localparam int unsigned PWM_DIV       = 40;            // duty step of 2.5 percent
  localparam int unsigned PWM_STEP      = PWM_PERIOD / PWM_DIV;
  localparam int unsigned BLINK_W       = 26;
  localparam int unsigned PWM_W         = 19;
  localparam int unsigned UV_FAIL_COUNT = 4;
  localparam logic [2:0]  UV_CNT_MAX    = 3'h4;
  localparam logic [1:0]  DUTY_RESET    = 2'h0;
  // duty in steps of 2.5 percent: 20, 10, 5, 2.5 percent
  localparam logic [5:0]  DUTY_20       = 6'h08;
  localparam logic [5:0]  DUTY_10       = 6'h04;
  localparam logic [5:0]  DUTY_5        = 6'h02;
  localparam logic [5:0]  DUTY_2P5      = 6'h01;

  typedef enum logic [1:0] {
    FOGP_CFG_1, FOGP_CFG_2, FOGP_CFG_3, FOGP_CFG_4
  } fogp_devcfg_e;

  typedef enum logic [2:0] {
    FOGP_NORMAL, FOGP_STOP, FOGP_SLEEP, FOGP_RESTART, FOGP_FAILSAFE
  } fogp_mode_e;

  typedef enum logic [1:0] {
    FOGP_PIN_FAIL, FOGP_PIN_OFF, FOGP_PIN_WAKE, FOGP_PIN_SWITCH
  } fogp_pinfn_e;

  typedef struct packed {
    logic watchdog_failure_flag_event;
    logic thermal_shutdown_level2;
    logic primary_regulator_short;
    logic overvoltage;
    logic undervoltage_event;
  } fogp_faults_s;

  typedef struct packed {
    logic [1:0] fn;     // fogp_pinfn_e encoding
    logic       high_side;
    logic       sw_on;
  } fogp_pincfg_s;

  typedef struct packed {
    logic o;
    logic oe;
  } fogp_pin_s;
endpackage : fogp_pkg
`default_nettype wire

// >>> verilog/fogp_wave.sv
/*
  fogp_wave: blink and pwm waveform counters for the pulsed fail outputs.
  Assumes the single 40 MHz clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module fogp_wave (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       run,
  input  wire logic [1:0] pwm_duty_select,
  output logic            blink_low,
  output logic            pwm_low
);
  localparam int unsigned BLINK_W = fogp_pkg::BLINK_W;
  localparam int unsigned PWM_W   = fogp_pkg::PWM_W;

  logic [fogp_pkg::BLINK_W-1:0] blink_cnt;
  logic [fogp_pkg::BLINK_W-1:0] next_blink_cnt;
  logic [fogp_pkg::PWM_W-1:0]   pwm_cnt;
  logic [fogp_pkg::PWM_W-1:0]   next_pwm_cnt;
  logic                         next_blink_low;
  logic                         next_pwm_low;
  logic [5:0]                   duty_steps;
  logic [fogp_pkg::PWM_W-1:0]   duty_cycles;

  // duty select decode
  function automatic logic [5:0] duty_of(input logic [1:0] sel);
    case (sel)
      2'h0:    duty_of = fogp_pkg::DUTY_20;
      2'h1:    duty_of = fogp_pkg::DUTY_10;
      2'h2:    duty_of = fogp_pkg::DUTY_5;
      default: duty_of = fogp_pkg::DUTY_2P5;
    endcase
  endfunction : duty_of

  // counters restart with each activation so the first phase is always active
  always_comb begin
    duty_steps  = duty_of(pwm_duty_select);
    duty_cycles = PWM_W'(duty_steps * fogp_pkg::PWM_STEP);
    next_blink_cnt = blink_cnt;
    next_pwm_cnt   = pwm_cnt;
    next_blink_low = 1'b0;
    next_pwm_low   = 1'b0;
    if (run) begin
      next_blink_cnt = (blink_cnt == BLINK_W'(fogp_pkg::BLINK_PERIOD - 1)) ? '0
                       : blink_cnt + 1'b1;
      next_pwm_cnt   = (pwm_cnt == PWM_W'(fogp_pkg::PWM_PERIOD - 1)) ? '0
                       : pwm_cnt + 1'b1;
      next_blink_low = (blink_cnt < BLINK_W'(fogp_pkg::BLINK_HALF));
      next_pwm_low   = (pwm_cnt < duty_cycles);
    end else begin
      next_blink_cnt = '0;
      next_pwm_cnt   = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      blink_cnt <= '0;
      pwm_cnt   <= '0;
      blink_low <= 1'b0;
      pwm_low   <= 1'b0;
    end else begin
      blink_cnt <= next_blink_cnt;
      pwm_cnt   <= next_pwm_cnt;
      blink_low <= next_blink_low;
      pwm_low   <= next_pwm_low;
    end
  end
endmodule : fogp_wave
`default_nettype wire

// >>> testbench/fogp_chk.sv
/*
  fogp_chk: port-level assertions for fogp_fail_logic.
  Assumes one clock domain and the synchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module fogp_chk (
  input wire logic                    clk,
  input wire logic                    reset,
  input wire fogp_pkg::fogp_faults_s  faults,
  input wire logic                    faults_present,
  input wire logic                    overvoltage_reset_enable,
  input wire logic [2:0]              sbc_mode,
  input wire logic                    wd_trigger_ok,
  input wire logic                    sleep_entry,
  input wire logic                    stop_wd_disable,
  input wire logic                    fail_test_activate,
  input wire logic                    failure_clear,
  input wire fogp_pkg::fogp_pincfg_s  blink_pin_cfg,
  input wire fogp_pkg::fogp_pincfg_s  second_alt_pin_cfg,
  input wire fogp_pkg::fogp_pin_s     static_fail_out,
  input wire fogp_pkg::fogp_pin_s     blink_fail_out,
  input wire fogp_pkg::fogp_pin_s     pwm_fail_out,
  input wire logic                    device_status_reg,
  input wire logic                    watchdog_failure_flag,
  input wire logic                    failsafe_request
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // status bit leads the pins by one cycle
  sequence fail_raise;
    device_status_reg ##1 static_fail_out.oe;
  endsequence
  sequence fail_drop;
    !device_status_reg ##1 !static_fail_out.oe;
  endsequence
  fail_together_a: assert property (
    $rose(static_fail_out.oe) && blink_pin_cfg.fn == 2'h0 && second_alt_pin_cfg.fn == 2'h0
    |-> blink_fail_out.oe && pwm_fail_out.oe) else $error("fail pins not together");
  hard_fault_a: assert property (
    faults.thermal_shutdown_level2 || faults.primary_regulator_short |=> fail_raise)
    else $error("hard fault did not trip");
  ov_gate_a: assert property (
    faults == 5'h02 && !overvoltage_reset_enable && !device_status_reg |=> !device_status_reg)
    else $error("ungated overvoltage tripped");
  failsafe_follow_a: assert property (
    faults.thermal_shutdown_level2 && !device_status_reg |=> ##1 failsafe_request)
    else $error("no fail-safe request");
  status_drives_a: assert property ($rose(device_status_reg) |=> static_fail_out.oe)
    else $error("status without outputs");
  clear_blocked_a: assert property (
    device_status_reg && (faults_present || watchdog_failure_flag) |=> device_status_reg)
    else $error("failure released too early");
  release_seq_a: assert property (
    device_status_reg && failure_clear && !faults_present && !watchdog_failure_flag
    && faults == 5'h00 && !fail_test_activate && sbc_mode == 3'h0 |=> fail_drop)
    else $error("failure not released");
  test_on_a: assert property ($rose(fail_test_activate) |-> ##[1:2] static_fail_out.oe)
    else $error("test bit did not activate");
  test_off_a: assert property (
    $fell(fail_test_activate) && !device_status_reg && !faults_present
    |-> ##[1:3] !static_fail_out.oe) else $error("test bit did not release");
  static_low_a: assert property (static_fail_out.oe |-> !static_fail_out.o)
    else $error("static output not low");
  wd_flag_clear_a: assert property (
    (wd_trigger_ok || sleep_entry || stop_wd_disable) && !faults.watchdog_failure_flag_event
    |=> !watchdog_failure_flag) else $error("watchdog flag kept");
endmodule : fogp_chk
bind fogp_fail_logic fogp_chk i_chk (.clk, .reset, .faults, .faults_present,
  .overvoltage_reset_enable, .sbc_mode, .wd_trigger_ok, .sleep_entry, .stop_wd_disable,
  .fail_test_activate, .failure_clear, .blink_pin_cfg, .second_alt_pin_cfg, .static_fail_out,
  .blink_fail_out, .pwm_fail_out, .device_status_reg, .watchdog_failure_flag, .failsafe_request);
`default_nettype wire

// >>> testbench/fogp_pins.sv
/*
  fogp_pins: lamps and loads on the two pulsed pins, a wake source on the blink pin only.
  Assumes lamp pull-ups hold undriven pins high.
*/
`timescale 1ns/100ps
`default_nettype none
module fogp_pins (
  input wire fogp_pkg::fogp_pin_s blink_fail_out,
  input wire fogp_pkg::fogp_pin_s pwm_fail_out,
  input wire logic                wake_src,
  output logic                    blink_pin_level,
  output logic                    pwm_pin_level
);
  // a driven pin wins; else the wake source or the lamp pull-up sets it
  assign blink_pin_level = blink_fail_out.oe ? blink_fail_out.o : wake_src;
  assign pwm_pin_level   = pwm_fail_out.oe ? pwm_fail_out.o : 1'b1;
endmodule : fogp_pins
`default_nettype wire

// >>> testbench/fogp_fail_logic_tb_top.sv
/*
  fogp_fail_logic_tb_top: self-checking bench for fogp_fail_logic.
  Assumes the pin model and the bound checker; inputs move on falling edges.
*/
`timescale 1ns/100ps
`default_nettype none
module fogp_fail_logic_tb_top;
  localparam int S = fogp_pkg::PWM_STEP;
  logic                   clk, reset, faults_present, overvoltage_reset_enable;
  logic                   fail_test_activate, wake_src, device_status_reg;
  logic                   watchdog_failure_flag, failsafe_request, blink_pin_level, pwm_pin_level;
  logic [4:0]             flt;
  logic [7:0]             pls;
  logic [1:0]             device_config, pwm_duty_select, wake_status_second, wake_level_status;
  logic [2:0]             sbc_mode;
  fogp_pkg::fogp_pincfg_s blink_pin_cfg, second_alt_pin_cfg;
  fogp_pkg::fogp_pin_s    static_fail_out, blink_fail_out, pwm_fail_out;
  int                     err_count, samples_checked, cycles;

  // pls: 0 clear, 1 trigger, 2 sleep, 3 stop disable, 4 uv recovered, 5 duty, 6 cfg, 7 wake clr
  fogp_fail_logic i_dut (.clk, .reset, .faults(fogp_pkg::fogp_faults_s'(flt)), .faults_present,
    .overvoltage_reset_enable, .device_config, .sbc_mode, .wd_trigger_ok(pls[1]),
    .sleep_entry(pls[2]), .stop_wd_disable(pls[3]), .uv_recovered(pls[4]), .fail_test_activate,
    .failure_clear(pls[0]), .pwm_duty_select, .duty_write(pls[5]), .blink_pin_cfg,
    .second_alt_pin_cfg, .cfg_write(pls[6]), .wake_clear(pls[7]), .blink_pin_level,
    .pwm_pin_level, .static_fail_out, .blink_fail_out, .pwm_fail_out, .device_status_reg,
    .watchdog_failure_flag, .failsafe_request, .wake_status_second, .wake_level_status);
  fogp_pins i_pins (.blink_fail_out, .pwm_fail_out, .wake_src, .blink_pin_level, .pwm_pin_level);

  // free-running clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // hang guard; the planned run takes about 80200 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      err_count++;
      $display("MISMATCH %0t timeout", $time);
      report_and_stop;
    end
  end
  task report_and_stop;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  // pulses end one edge early so back-to-back calls never collide
  task pulse(input int k);
    pls[k] = 1'b1;
    cyc(1);
    pls = '0;
    cyc(1);
  endtask : pulse
  task fpulse(input logic [4:0] f);
    flt = f;
    cyc(1);
    flt = '0;
    cyc(1);
  endtask : fpulse
  task fst(input logic e);
    chk(device_status_reg === e && static_fail_out.oe === e, "failure state");
  endtask : fst
  task do_reset;
    reset = 1'b1;
    cyc(10);
    reset = 1'b0;
    cyc(1);
  endtask : do_reset
  // mode 7 skips the duty write; lo equal to hi means only a lower bound
  task run_duty(input logic [1:0] code, input logic [2:0] mode, input int lo, input int hi);
    int n;
    n = 0;
    if (mode != 3'h7) begin
      sbc_mode = mode;
      pwm_duty_select = code;
      pulse(5);
      sbc_mode = 3'h0;
    end
    fail_test_activate = 1'b1;
    while (pwm_fail_out.oe !== 1'b1 && n < 4) begin
      n++;
      cyc(1);
    end
    n = 0;
    while (pwm_fail_out.oe === 1'b1 && n < hi) begin
      n++;
      cyc(1);
    end
    chk(n >= lo && (n < hi || lo == hi), "pwm duty");
    chk(static_fail_out.oe === 1'b1 && blink_fail_out.oe === 1'b1, "static or blink");
    fail_test_activate = 1'b0;
    cyc(4);
    chk(static_fail_out.oe === 1'b0 && pwm_fail_out.oe === 1'b0, "test release");
  endtask : run_duty
  task t_faults;
    for (int i = 0; i < 4; i++) begin
      overvoltage_reset_enable = i[0];
      faults_present = 1'b1;
      fpulse((i == 0) ? 5'h08 : (i == 1) ? 5'h04 : 5'h02);
      fst(i != 2);
      if (i != 2) chk(blink_fail_out.oe & pwm_fail_out.oe & failsafe_request, "trip");
      pulse(0);
      chk(device_status_reg === (i != 2), "early release");
      faults_present = 1'b0;
      pulse(0);
      fst(1'b0);
    end
  endtask : t_faults
  task t_uv;
    repeat (3) fpulse(5'h01);
    pulse(4);
    repeat (3) fpulse(5'h01);
    fst(1'b0);
    fpulse(5'h01);
    fst(1'b1);
    pulse(0);
    fst(1'b0);
  endtask : t_uv
  task t_pins;
    blink_pin_cfg = '{2'h2, 1'b0, 1'b0};
    second_alt_pin_cfg = '{2'h3, 1'b1, 1'b1};
    pulse(6);
    cyc(4);
    chk(pwm_fail_out.o & pwm_fail_out.oe & wake_level_status[1], "switch");
    wake_src = 1'b0;
    cyc(4);
    chk(wake_status_second[0] === 1'b1 && wake_level_status[0] === 1'b0, "wake");
    pulse(7);
    sbc_mode = 3'h3;
    wake_src = 1'b1;
    cyc(4);
    chk(wake_status_second === 2'h1 && pwm_fail_out.oe === 1'b0, "restart");
    sbc_mode = 3'h0;
    pulse(7);
    chk(pwm_fail_out.oe === 1'b1 && wake_status_second === 2'h0, "resume");
    sbc_mode = 3'h4;
    second_alt_pin_cfg.fn = 2'h1;
    pulse(6);
    wake_src = 1'b0;
    cyc(4);
    chk(wake_status_second === 2'h0 && pwm_fail_out.oe === 1'b0, "fail-safe");
    sbc_mode = 3'h0;
    cyc(3);
    chk(pwm_fail_out.oe === 1'b1, "config kept");
    pulse(6);
    cyc(2);
    chk(pwm_fail_out.oe === 1'b0, "off");
    blink_pin_cfg = '0;
    second_alt_pin_cfg = '0;
    wake_src = 1'b1;
    pulse(6);
  endtask : t_pins
  task t_wd;
    for (int c = 0; c < 4; c++) begin
      device_config = c[1:0];
      do_reset;
      fpulse(5'h10);
      fst(c == 0);
      fpulse(5'h10);
      fst(1'b1);
      chk(watchdog_failure_flag === 1'b1, "wd flag");
      pulse(0);
      chk(device_status_reg === 1'b1, "release with wd flag");
      pulse(c < 2 ? 1 : c);
      chk(watchdog_failure_flag === 1'b0, "wd flag kept");
      pulse(0);
      fst(1'b0);
    end
  endtask : t_wd
  // main sequence
  initial begin
    {reset, faults_present, overvoltage_reset_enable, fail_test_activate} = 4'h8;
    {flt, pls, device_config, pwm_duty_select, sbc_mode} = '0;
    {blink_pin_cfg, second_alt_pin_cfg} = '0;
    {wake_src, err_count, samples_checked, cycles} = {1'b1, 96'h0};
    do_reset;
    run_duty(2'h0, 3'h7, 2 * S, 2 * S);
    run_duty(2'h1, 3'h0, 2 * S, 2 * S);
    run_duty(2'h3, 3'h0, S - 1, S + 2);
    run_duty(2'h2, 3'h1, S - 1, S + 2);
    run_duty(2'h2, 3'h0, 2 * S - 1, 2 * S + 2);
    t_faults;
    t_uv;
    t_pins;
    t_wd;
    report_and_stop;
  end
endmodule : fogp_fail_logic_tb_top
`default_nettype wire
